/* File: rtl/lbt_engine.sv */
// Purpose: line/point drawing and block copy engine with apb registers
// Assumes: frame buffer port answers each request with a one-cycle ack
// Notes: commands stall apb while the engine is busy, there is no fifo
//
// Chosen here: the placing of the registers and the APB interface to the registers.

// How it works
// - line or point starts at corner point a
// - line ends at corner point c, unused for a single point
// - line ignores major-axis step, point ignores both steps
// - every line pixel is written with the foreground value
// - line command write latches line options and starts drawing
// - pixels are converted when source and output formats differ
// - 4:2:2 luma/chroma source is accepted for block copy
// - transparent mode drops source pixels equal to backdrop value
// - block copy source comes from memory or from the host
// - stretched source coordinates round to the nearest integer
// - horizontal step above one shrinks, below one stretches
// - vertical step above one shrinks, below one stretches
// - steps ignored without scale flag or with host source
// - corner a is source start, b is only stored, c,d are destination rectangle
// - source origin only for memory copies, output origin is destination
// - block copy command write starts a memory copy, scaled if flagged
// - first host pixel starts host copy, rest follow one per write
module lbt_engine
  import lbt_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame buffer master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_be,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // status
  output logic busy
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] corner_a_ff, corner_b_ff, corner_c_ff, corner_d_ff;
  logic [STW-1:0] hstep_ff, vstep_ff;
  logic [31:0] fg_ff, bg_ff, src_org_ff, out_org_ff, hpix_ff;
  logic [WW-1:0] src_w_ff, out_w_ff;
  logic [1:0] src_fmt_ff, out_fmt_ff;
  logic transp_ff, major_y_ff, point_ff, scale_ff, host_ff, is_line_ff, hvld_ff;
  logic pready_ff, pslverr_ff, busy_ff;
  logic [31:0] prdata_ff;
  logic mem_req_ff, mem_we_ff;
  logic [31:0] mem_addr_ff, mem_wdata_ff;
  logic [3:0] mem_be_ff;
  lbt_state_t st_ff, nxt_st;
  logic [CW-1:0] lmaj_ff, lend_ff, dx_ff, dy_ff;
  logic ldec_ff;
  logic signed [STW-1:0] lmin_ff;
  logic [STW-1:0] sx_acc_ff, sy_acc_ff;
  logic [31:0] spix_ff;
  logic sodd_ff;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic setup_ok, stall, wr_acc, is_cmd;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign is_cmd = paddr == OFS_LINE_CMD || paddr == OFS_BLK_CMD || paddr == OFS_HOST_FIRST;
  // commands and host pixels wait instead of being lost
  assign stall = pwrite && ((is_cmd && busy_ff) || (paddr == OFS_HOST_REST && hvld_ff));
  assign setup_ok = psel && penable && !pready_ff && !stall;
  assign wr_acc = psel && penable && pready_ff && pwrite;

  always_comb
  begin
    rd_hit = 1'b1;
    case (paddr)
      OFS_STATUS: rd_mux = {30'h0, hvld_ff, busy_ff};
      OFS_CORNER_A: rd_mux = corner_a_ff;
      OFS_CORNER_B: rd_mux = corner_b_ff;
      OFS_CORNER_C: rd_mux = corner_c_ff;
      OFS_CORNER_D: rd_mux = corner_d_ff;
      OFS_HSTEP: rd_mux = {9'h0, hstep_ff};
      OFS_VSTEP: rd_mux = {9'h0, vstep_ff};
      OFS_FG: rd_mux = fg_ff;
      OFS_BG: rd_mux = bg_ff;
      OFS_LINE_CMD: rd_mux = {30'h0, point_ff, major_y_ff};
      OFS_BLK_CMD: rd_mux = {31'h0, scale_ff};
      OFS_MODE: rd_mux = {31'h0, transp_ff};
      OFS_HOST_FIRST, OFS_HOST_REST: rd_mux = hpix_ff;
      OFS_SRC_ORG: rd_mux = src_org_ff;
      OFS_OUT_ORG: rd_mux = out_org_ff;
      OFS_SRC_WIDTH: rd_mux = {20'h0, src_w_ff};
      OFS_OUT_WIDTH: rd_mux = {20'h0, out_w_ff};
      OFS_SRC_FMT: rd_mux = {30'h0, src_fmt_ff};
      OFS_OUT_FMT: rd_mux = {30'h0, out_fmt_ff};
      default:
      begin
        rd_mux = RST_WORD;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= RST_WORD;
    end
    else
    begin
      pready_ff <= setup_ok;
      pslverr_ff <= setup_ok && !rd_hit;
      if (setup_ok && !pwrite)
        prdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------
  // parameter registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      corner_a_ff <= RST_WORD;
      corner_b_ff <= RST_WORD;
      corner_c_ff <= RST_WORD;
      corner_d_ff <= RST_WORD;
      hstep_ff <= '0;
      vstep_ff <= '0;
      fg_ff <= RST_WORD;
      bg_ff <= RST_WORD;
      src_org_ff <= RST_WORD;
      out_org_ff <= RST_WORD;
      src_w_ff <= '0;
      out_w_ff <= '0;
      src_fmt_ff <= FMT_RGB565;
      out_fmt_ff <= FMT_RGB565;
      transp_ff <= 1'b0;
    end
    else if (wr_acc)
    begin
      case (paddr)
        OFS_CORNER_A: corner_a_ff <= pwdata;
        OFS_CORNER_B: corner_b_ff <= pwdata;
        OFS_CORNER_C: corner_c_ff <= pwdata;
        OFS_CORNER_D: corner_d_ff <= pwdata;
        OFS_HSTEP: hstep_ff <= pwdata[STW-1:0];
        OFS_VSTEP: vstep_ff <= pwdata[STW-1:0];
        OFS_FG: fg_ff <= pwdata;
        OFS_BG: bg_ff <= pwdata;
        OFS_SRC_ORG: src_org_ff <= pwdata;
        OFS_OUT_ORG: out_org_ff <= pwdata;
        OFS_SRC_WIDTH: src_w_ff <= pwdata[WW-1:0];
        OFS_OUT_WIDTH: out_w_ff <= pwdata[WW-1:0];
        OFS_SRC_FMT: src_fmt_ff <= pwdata[1:0];
        OFS_OUT_FMT: out_fmt_ff <= pwdata[1:0];
        OFS_MODE: transp_ff <= pwdata[MODE_TRANSP];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // command capture and host pixels
  // ----------------------------------------
  logic line_go, blk_go, host_go, host_rest, pix_take;
  assign line_go = wr_acc && paddr == OFS_LINE_CMD;
  assign blk_go = wr_acc && paddr == OFS_BLK_CMD;
  assign host_go = wr_acc && paddr == OFS_HOST_FIRST;
  assign host_rest = wr_acc && paddr == OFS_HOST_REST && host_ff && busy_ff;
  assign pix_take = st_ff == ST_BLK_PIX && host_ff && hvld_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      major_y_ff <= 1'b0;
      point_ff <= 1'b0;
      scale_ff <= 1'b0;
      host_ff <= 1'b0;
      is_line_ff <= 1'b0;
    end
    else if (line_go)
    begin
      major_y_ff <= pwdata[LCMD_MAJOR_Y];
      point_ff <= pwdata[LCMD_POINT];
      is_line_ff <= 1'b1;
    end
    else if (blk_go || host_go)
    begin
      scale_ff <= blk_go && pwdata[BCMD_SCALE];
      host_ff <= host_go;
      is_line_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hvld_ff <= 1'b0;
      hpix_ff <= RST_WORD;
    end
    else if (host_go || host_rest)
    begin
      hvld_ff <= 1'b1;
      hpix_ff <= pwdata;
    end
    else if (pix_take)
      hvld_ff <= 1'b0;
  end

  // ----------------------------------------
  // coordinates and addresses
  // ----------------------------------------
  logic [STW-1:0] lmin_rnd, sx_rnd, sy_rnd, hinc, vinc;
  logic [CW-1:0] dst_x, dst_y, src_x, src_y;
  logic [31:0] dst_lin, src_lin, dst_addr, src_addr, conv_pix, wr_data;
  logic line_end, row_end, blk_end, drop, blk_adv;

  assign lmin_rnd = lmin_ff + STEP_HALF;
  assign sx_rnd = sx_acc_ff + STEP_HALF;
  assign sy_rnd = sy_acc_ff + STEP_HALF;
  assign src_x = sx_rnd[FRAC+CW-1:FRAC];
  assign src_y = sy_rnd[FRAC+CW-1:FRAC];
  assign dst_x = !is_line_ff ? dx_ff : (major_y_ff ? lmin_rnd[FRAC+CW-1:FRAC] : lmaj_ff);
  assign dst_y = !is_line_ff ? dy_ff : (major_y_ff ? lmaj_ff : lmin_rnd[FRAC+CW-1:FRAC]);
  // steps only for scaled memory copy
  assign hinc = scale_ff && !host_ff ? hstep_ff : STEP_ONE;
  assign vinc = scale_ff && !host_ff ? vstep_ff : STEP_ONE;
  assign dst_lin = 32'(dst_y) * 32'(out_w_ff) + 32'(dst_x);
  assign src_lin = 32'(src_y) * 32'(src_w_ff) + 32'(src_x);
  assign dst_addr = out_org_ff + (out_fmt_ff == FMT_ARGB8888 ? dst_lin << 2 : dst_lin << 1);
  assign src_addr = src_org_ff + (src_fmt_ff == FMT_ARGB8888 ? src_lin << 2 :
                    src_fmt_ff == FMT_YCC422 ? {src_lin[30:1], 2'b00} : src_lin << 1);
  assign line_end = point_ff || lmaj_ff == lend_ff;
  assign row_end = dx_ff == corner_d_ff[X_LSB +: CW];
  assign blk_end = row_end && dy_ff == corner_d_ff[Y_LSB +: CW];
  assign drop = transp_ff && (src_fmt_ff == FMT_ARGB8888 ? spix_ff == bg_ff :
                spix_ff[15:0] == bg_ff[15:0]);
  assign blk_adv = (st_ff == ST_BLK_CHK && drop) || (st_ff == ST_BLK_WR && mem_ack);
  assign wr_data = is_line_ff ? fg_ff : conv_pix;

  lbt_pix_conv u_conv (
    .src_fmt(src_fmt_ff),
    .dst_fmt(out_fmt_ff),
    .pix_in(spix_ff),
    .odd(sodd_ff),
    .pix_out(conv_pix)
  );

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:
        if (line_go)
          nxt_st = ST_LINE_PIX;
        else if (blk_go || host_go)
          nxt_st = ST_BLK_PIX;
      ST_LINE_PIX: nxt_st = ST_LINE_WR;
      ST_LINE_WR:
        if (mem_ack)
          nxt_st = line_end ? ST_IDLE : ST_LINE_PIX;
      ST_BLK_PIX:
        if (!host_ff)
          nxt_st = ST_BLK_RD;
        else if (hvld_ff)
          nxt_st = ST_BLK_CHK;
      ST_BLK_RD:
        if (mem_ack)
          nxt_st = ST_BLK_CHK;
      ST_BLK_CHK: nxt_st = drop ? (blk_end ? ST_IDLE : ST_BLK_PIX) : ST_BLK_WR;
      ST_BLK_WR:
        if (mem_ack)
          nxt_st = blk_end ? ST_IDLE : ST_BLK_PIX;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= ST_IDLE;
      busy_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      busy_ff <= nxt_st != ST_IDLE;
    end
  end

  // ----------------------------------------
  // line walker
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lmaj_ff <= '0;
      lend_ff <= '0;
      ldec_ff <= 1'b0;
      lmin_ff <= '0;
    end
    else if (line_go && !busy_ff)
    begin
      lmaj_ff <= pwdata[LCMD_MAJOR_Y] ? corner_a_ff[Y_LSB +: CW] : corner_a_ff[X_LSB +: CW];
      lend_ff <= pwdata[LCMD_MAJOR_Y] ? corner_c_ff[Y_LSB +: CW] : corner_c_ff[X_LSB +: CW];
      ldec_ff <= pwdata[LCMD_MAJOR_Y] ? corner_c_ff[Y_LSB +: CW] < corner_a_ff[Y_LSB +: CW] :
                 corner_c_ff[X_LSB +: CW] < corner_a_ff[X_LSB +: CW];
      lmin_ff <= {1'b0, pwdata[LCMD_MAJOR_Y] ? corner_a_ff[X_LSB +: CW] : corner_a_ff[Y_LSB +: CW],
                  11'h000};
    end
    else if (st_ff == ST_LINE_WR && mem_ack && !line_end)
    begin
      lmaj_ff <= ldec_ff ? lmaj_ff - 11'h001 : lmaj_ff + 11'h001;
      lmin_ff <= lmin_ff + $signed(major_y_ff ? hstep_ff : vstep_ff);
    end
  end

  // ----------------------------------------
  // block walker
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dx_ff <= '0;
      dy_ff <= '0;
      sx_acc_ff <= '0;
      sy_acc_ff <= '0;
    end
    // a is source, c is destination start
    else if ((blk_go || host_go) && !busy_ff)
    begin
      dx_ff <= corner_c_ff[X_LSB +: CW];
      dy_ff <= corner_c_ff[Y_LSB +: CW];
      sx_acc_ff <= {1'b0, corner_a_ff[X_LSB +: CW], 11'h000};
      sy_acc_ff <= {1'b0, corner_a_ff[Y_LSB +: CW], 11'h000};
    end
    else if (blk_adv && !row_end)
    begin
      dx_ff <= dx_ff + 11'h001;
      sx_acc_ff <= sx_acc_ff + hinc;
    end
    else if (blk_adv && !blk_end)
    begin
      dx_ff <= corner_c_ff[X_LSB +: CW];
      dy_ff <= dy_ff + 11'h001;
      sx_acc_ff <= {1'b0, corner_a_ff[X_LSB +: CW], 11'h000};
      sy_acc_ff <= sy_acc_ff + vinc;
    end
  end

  // ----------------------------------------
  // frame buffer requests
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= RST_WORD;
      mem_wdata_ff <= RST_WORD;
      mem_be_ff <= 4'h0;
      spix_ff <= RST_WORD;
      sodd_ff <= 1'b0;
    end
    else if (mem_req_ff)
    begin
      if (mem_ack)
      begin
        mem_req_ff <= 1'b0;
        if (!mem_we_ff)
          spix_ff <= src_fmt_ff == FMT_RGB565 && mem_addr_ff[1] ? {16'h0, mem_rdata[31:16]} : mem_rdata;
      end
    end
    else if (st_ff == ST_BLK_PIX && !host_ff)
    begin
      mem_req_ff <= 1'b1;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= src_addr;
      mem_be_ff <= 4'hf;
      sodd_ff <= src_x[0];
    end
    else if (pix_take)
    begin
      spix_ff <= hpix_ff;
      sodd_ff <= dx_ff[0];
    end
    else if (st_ff == ST_LINE_PIX || (st_ff == ST_BLK_CHK && !drop))
    begin
      mem_req_ff <= 1'b1;
      mem_we_ff <= 1'b1;
      mem_addr_ff <= dst_addr;
      mem_wdata_ff <= out_fmt_ff == FMT_ARGB8888 ? wr_data : {wr_data[15:0], wr_data[15:0]};
      mem_be_ff <= out_fmt_ff == FMT_ARGB8888 ? 4'hf : (dst_addr[1] ? 4'hc : 4'h3);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign mem_req = mem_req_ff;
  assign mem_we = mem_we_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_be = mem_be_ff;
  assign busy = busy_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence line_cmd_s;
    line_go && !busy_ff;
  endsequence
  sequence line_wr_s;
    st_ff == ST_LINE_PIX ##1 mem_req_ff && mem_we_ff;
  endsequence

  line_start_a: assert property (line_cmd_s |=> line_wr_s)
    else $error("line command did not start a write");
  line_origin_a: assert property (line_cmd_s |=> lmaj_ff == (major_y_ff ? corner_a_ff[Y_LSB +: CW] :
    corner_a_ff[X_LSB +: CW]))
    else $error("line did not start at corner a");
  line_paint_a: assert property (mem_req_ff && mem_we_ff && is_line_ff && out_fmt_ff == FMT_ARGB8888
    |-> mem_wdata_ff == fg_ff)
    else $error("line pixel not in foreground value");
  line_unit_a: assert property (st_ff == ST_LINE_WR && mem_ack && !line_end
    |=> (lmaj_ff - $past(lmaj_ff)) == 11'h001 || ($past(lmaj_ff) - lmaj_ff) == 11'h001)
    else $error("major axis moved by other than one");
  point_once_a: assert property (st_ff == ST_LINE_WR && mem_ack && point_ff |=> st_ff == ST_IDLE)
    else $error("point drew more than one pixel");
  drop_skip_a: assert property (st_ff == ST_BLK_CHK && drop |=> !mem_req_ff ##1 !(mem_req_ff && mem_we_ff))
    else $error("dropped pixel was written");
  blk_start_a: assert property (blk_go && !busy_ff |=> st_ff == ST_BLK_PIX && !host_ff ##1 mem_req_ff)
    else $error("block copy command did not start a read");
  host_start_a: assert property (host_go && !busy_ff |=> host_ff && hvld_ff && st_ff == ST_BLK_PIX)
    else $error("host pixel did not start a copy");
  unscaled_a: assert property (blk_adv && !row_end && (!scale_ff || host_ff)
    |=> sx_acc_ff == $past(sx_acc_ff) + STEP_ONE)
    else $error("step used while it should be ignored");
endmodule

/* File: rtl/lbt_pkg.sv */
// Purpose: shared constants and types of the line and block copy engine
// Assumes: 32-bit apb, one pclk domain
// Notes: coordinates are 11-bit integers, steps are 12.11 fixed point
package lbt_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CORNER_A = 8'h04;
  localparam logic [7:0] OFS_CORNER_B = 8'h08;
  localparam logic [7:0] OFS_CORNER_C = 8'h0c;
  localparam logic [7:0] OFS_CORNER_D = 8'h10;
  localparam logic [7:0] OFS_HSTEP = 8'h14;
  localparam logic [7:0] OFS_VSTEP = 8'h18;
  localparam logic [7:0] OFS_FG = 8'h1c;
  localparam logic [7:0] OFS_BG = 8'h20;
  localparam logic [7:0] OFS_LINE_CMD = 8'h24;
  localparam logic [7:0] OFS_BLK_CMD = 8'h28;
  localparam logic [7:0] OFS_MODE = 8'h2c;
  localparam logic [7:0] OFS_HOST_FIRST = 8'h30;
  localparam logic [7:0] OFS_HOST_REST = 8'h34;
  localparam logic [7:0] OFS_SRC_ORG = 8'h38;
  localparam logic [7:0] OFS_OUT_ORG = 8'h3c;
  localparam logic [7:0] OFS_SRC_WIDTH = 8'h40;
  localparam logic [7:0] OFS_OUT_WIDTH = 8'h44;
  localparam logic [7:0] OFS_SRC_FMT = 8'h48;
  localparam logic [7:0] OFS_OUT_FMT = 8'h4c;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int X_LSB = 0;
  localparam int Y_LSB = 16;
  localparam int CW = 11;
  localparam int WW = 12;
  localparam int STW = 23;
  localparam int FRAC = 11;
  localparam int LCMD_MAJOR_Y = 0;
  localparam int LCMD_POINT = 1;
  localparam int BCMD_SCALE = 0;
  localparam int MODE_TRANSP = 0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [STW-1:0] STEP_ONE = 23'h000800;
  localparam logic [STW-1:0] STEP_HALF = 23'h000400;
  // ----------------------------------------
  // pixel formats and engine states
  // ----------------------------------------
  localparam logic [1:0] FMT_RGB565 = 2'h0;
  localparam logic [1:0] FMT_ARGB8888 = 2'h1;
  localparam logic [1:0] FMT_YCC422 = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LINE_PIX, ST_LINE_WR, ST_BLK_PIX, ST_BLK_RD, ST_BLK_CHK, ST_BLK_WR
  } lbt_state_t;
endpackage

/* File: rtl/lbt_pix_conv.sv */
// Purpose: source to output pixel format conversion
// Assumes: 16-bit pixels sit in the low half of pix_in
// Notes: luma/chroma input is y0 cb y1 cr, low byte first
module lbt_pix_conv
  import lbt_pkg::*;
(
  // formats
  input wire logic [1:0] src_fmt,
  input wire logic [1:0] dst_fmt,
  // pixel
  input wire logic [31:0] pix_in,
  input wire logic odd,
  output logic [31:0] pix_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] clamp8(input logic signed [10:0] v);
    clamp8 = v < 0 ? 8'h00 : (v > 11'sd255 ? 8'hff : v[7:0]);
  endfunction

  logic [31:0] argb;
  logic signed [10:0] ys, cbd, crd;

  // ----------------------------------------
  // expand to argb, then pack
  // ----------------------------------------
  always_comb
  begin
    ys = {3'h0, odd ? pix_in[23:16] : pix_in[7:0]};
    cbd = $signed({3'h0, pix_in[15:8]}) - 11'sd128;
    crd = $signed({3'h0, pix_in[31:24]}) - 11'sd128;
    case (src_fmt)
      FMT_RGB565: argb = {8'hff, pix_in[15:11], pix_in[15:13], pix_in[10:5], pix_in[10:9],
                          pix_in[4:0], pix_in[4:2]};
      // shift-add coefficients trade a little accuracy for no multipliers
      FMT_YCC422: argb = {8'hff, clamp8(ys + crd + (crd >>> 2) + (crd >>> 3)),
                          clamp8(ys - (cbd >>> 2) - (crd >>> 1) - (crd >>> 3)),
                          clamp8(ys + cbd + (cbd >>> 1) + (cbd >>> 2))};
      default: argb = pix_in;
    endcase
    if (src_fmt == dst_fmt)
      pix_out = pix_in;
    else if (dst_fmt == FMT_RGB565)
      pix_out = {16'h0000, argb[23:19], argb[15:10], argb[7:3]};
    else
      pix_out = argb;
  end
endmodule

/* File: sim/lbt_fb_model.sv */
// Purpose: frame buffer model answering the engine
// Assumes: 256 words, byte address bits [9:2]
// Notes: slow adds three wait cycles per ack
module lbt_fb_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  input wire logic slow,
  // answer
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic [31:0] rd_ff;
  logic [1:0] cnt_ff;
  logic ack_ff;
  // idle bus flips so stale data never looks valid
  assign mem_rdata = ack_ff ? rd_ff : ~rd_ff;
  assign mem_ack = ack_ff;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_ff <= 1'b0;
      cnt_ff <= 2'h0;
      rd_ff <= 32'h0;
    end
    else if (mem_req && !ack_ff && (!slow || cnt_ff == 2'h3))
    begin
      ack_ff <= 1'b1;
      cnt_ff <= 2'h0;
      rd_ff <= mem[mem_addr[9:2]];
      for (int b = 0; b < 4; b++)
        if (mem_we && mem_be[b]) mem[mem_addr[9:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
    end
    else
    begin
      ack_ff <= 1'b0;
      cnt_ff <= (mem_req && !ack_ff) ? cnt_ff + 2'h1 : 2'h0;
    end
  end
endmodule

/* File: sim/lbt_engine_tb.sv */
// Purpose: self-checking bench for the line and block copy engine
// Assumes: apb master tasks, 16-pixel lines of 32-bit pixels
// Notes: one pixel per frame buffer word
module lbt_engine_tb
  import lbt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, s;
  logic mem_req, mem_we, mem_ack, busy, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, q;
  logic [3:0] mem_be;
  int err_count = 0;
  int tests_run = 0;
  always #10 pclk = ~pclk;
  lbt_engine u_lbt_engine (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));
  lbt_fb_model u_lbt_fb_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .slow(slow), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // ----
  // tasks
  // ----
  task complete_run;
    $display("checks %0d bad %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // commands stall while busy, so the wait bound is generous
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look between edges, where pready has settled for the next rising edge
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 3000);
    if (n >= 3000)
    begin
      chk("apb_wait", 32'h0, 32'h1);
      complete_run;
    end
    q = prdata;
    s = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_idle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 500);
    if (n >= 500)
    begin
      chk("busy_wait", 32'h0, 32'h1);
      complete_run;
    end
  endtask
  task cmem(input string nm, input int x, input int y, input logic [31:0] e);
    chk(nm, u_lbt_fb_model.mem[y * 16 + x], e);
  endtask
  // ----
  // tests
  // ----
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, slow, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_FG, 32'h0);
    chk("fg_reset", q, RST_WORD);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", {31'h0, s}, 32'h1);
    apb(1'b1, OFS_SRC_FMT, {30'h0, FMT_ARGB8888});
    apb(1'b1, OFS_OUT_FMT, {30'h0, FMT_ARGB8888});
    apb(1'b1, OFS_SRC_WIDTH, 32'h10);
    apb(1'b1, OFS_OUT_WIDTH, 32'h10);
    apb(1'b1, OFS_CORNER_C, 32'h0001_0003);
    apb(1'b1, OFS_HSTEP, 32'h7ff);
    apb(1'b1, OFS_VSTEP, 32'h2ab);
    apb(1'b1, OFS_FG, 32'h1234_5678);
    apb(1'b1, OFS_LINE_CMD, 32'h0);
    chk("busy_on", {31'h0, busy}, 32'h1);
    wait_idle;
    chk("busy_off", {31'h0, busy}, 32'h0);
    cmem("line0", 0, 0, 32'h1234_5678);
    cmem("line1", 1, 0, 32'h1234_5678);
    cmem("line2", 2, 1, 32'h1234_5678);
    cmem("line3", 3, 1, 32'h1234_5678);
    cmem("line_gap", 2, 0, 32'h0);
    $display("line test done");
    apb(1'b1, OFS_CORNER_A, 32'h0002_0005);
    apb(1'b1, OFS_LINE_CMD, 32'h2);
    wait_idle;
    cmem("point", 5, 2, 32'h1234_5678);
    cmem("point_only", 4, 2, 32'h0);
    $display("point test done");
    apb(1'b1, OFS_CORNER_C, 32'h0007_0000);
    apb(1'b1, OFS_CORNER_D, 32'h0007_0001);
    apb(1'b1, OFS_HOST_FIRST, 32'ha5a5_0001);
    apb(1'b1, OFS_HOST_REST, 32'h5a5a_0002);
    wait_idle;
    cmem("host0", 0, 7, 32'ha5a5_0001);
    cmem("host1", 1, 7, 32'h5a5a_0002);
    $display("host test done");
    u_lbt_fb_model.mem[128] = 32'h0000_00bb;
    u_lbt_fb_model.mem[129] = 32'hcafe_f00d;
    apb(1'b1, OFS_SRC_ORG, 32'h200);
    apb(1'b1, OFS_CORNER_A, 32'h0);
    apb(1'b1, OFS_CORNER_B, 32'h1);
    apb(1'b1, OFS_CORNER_C, 32'h0004_0003);
    apb(1'b1, OFS_CORNER_D, 32'h0004_0004);
    apb(1'b1, OFS_BG, 32'hbb);
    apb(1'b1, OFS_MODE, 32'h1);
    apb(1'b1, OFS_BLK_CMD, 32'h0);
    wait_idle;
    cmem("transp", 3, 4, 32'h0);
    cmem("copy", 4, 4, 32'hcafe_f00d);
    $display("copy test done");
    slow <= 1'b1;
    apb(1'b1, OFS_MODE, 32'h0);
    apb(1'b1, OFS_CORNER_C, 32'h0005_0000);
    apb(1'b1, OFS_CORNER_D, 32'h0005_0003);
    apb(1'b1, OFS_HSTEP, 32'h2ab);
    apb(1'b1, OFS_VSTEP, 32'h800);
    apb(1'b1, OFS_BLK_CMD, 32'h1);
    wait_idle;
    for (int i = 0; i < 4; i++)
      cmem("stretch", i, 5, (i < 2) ? 32'hbb : 32'hcafe_f00d);
    $display("stretch test done");
    apb(1'b1, OFS_SRC_FMT, {30'h0, FMT_RGB565});
    apb(1'b1, OFS_CORNER_C, 32'h0009_0000);
    apb(1'b1, OFS_CORNER_D, 32'h0009_0000);
    apb(1'b1, OFS_BLK_CMD, 32'h0);
    wait_idle;
    cmem("convert", 0, 9, 32'hff00_14de);
    $display("convert test done");
    apb(1'b1, OFS_SRC_FMT, {30'h0, FMT_ARGB8888});
    apb(1'b1, OFS_SRC_ORG, 32'h0);
    apb(1'b1, OFS_CORNER_A, 32'h0007_0000);
    apb(1'b1, OFS_CORNER_C, 32'h0007_0002);
    apb(1'b1, OFS_CORNER_D, 32'h0007_0003);
    apb(1'b1, OFS_BLK_CMD, 32'h0);
    wait_idle;
    cmem("onscreen0", 2, 7, 32'ha5a5_0001);
    cmem("onscreen1", 3, 7, 32'h5a5a_0002);
    $display("on-screen test done");
    complete_run;
  end
endmodule
